// [rtl/csp_clock_power.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module csp_clock_power #(
   parameter int WAKE_W = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic slow_tick_in,
   input wire logic ext_tick_in,
   input wire logic [WAKE_W-1:0] wake_irq_in,
   input wire logic [WAKE_W-1:0] irq_enabled_in,
   input wire logic periph_irq_in,
   output csp_pkg::csp_clk_ctl_t clk_ctl_out,
   output logic core_periph_blocked_out,
   output logic vector_req_out,
   output logic resume_next_out,
   output logic [2:0] mode_out
);
   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   if (WAKE_W != 8) begin : g_bad_width
      $error("wake mask width must be 8");
   end

   csp_pkg::csp_state_t state_r;
   csp_pkg::csp_state_t state_nxt;
   logic smod_r;
   logic lower_bit_r;
   logic autosw_r;
   logic [3:0] prediv_r;
   logic [1:0] rdy_sel_r;
   logic [1:0] src_r;
   logic [7:0] wakeup_source_mask_r;
   logic [8:0] tab_cnt_r;
   logic tab_key_r;
   logic [WAKE_W-1:0] irq_prev_r;
   logic [8:0] rdy_cnt_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic tab_open;
   logic wr_pwr;
   logic wr_prot;
   logic [WAKE_W-1:0] irq_edge;
   logic wake_hit;
   logic wake_vec;
   logic idle_exit;
   logic osc_run;
   logic prediv_tick;
   logic sys_tick;
   logic [8:0] rdy_limit;

   assign tab_open = (tab_cnt_r != 9'h000);
   assign wr_pwr = wr_in && (addr_in == csp_pkg::PWR_ADDR);
   assign wr_prot = wr_in && tab_open;

   // ----------------------------------------
   // clock source
   // ----------------------------------------
   assign osc_run = (state_r == csp_pkg::CSP_RUN) || (state_r == csp_pkg::CSP_IDLE);

   csp_prediv u_prediv (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .run_in(osc_run),
      .code_in(prediv_r),
      .tick_out(prediv_tick)
   );

   always_comb begin
      if (!osc_run) begin
         sys_tick = 1'b0;
      end else if (src_r == csp_pkg::SRC_SLOW) begin
         sys_tick = slow_tick_in;
      end else if (src_r == csp_pkg::SRC_EXT) begin
         sys_tick = ext_tick_in;
      end else begin
         sys_tick = prediv_tick;
      end
   end

   always_comb begin
      clk_ctl_out.sys_en = sys_tick;
      clk_ctl_out.core_en = sys_tick && (state_r == csp_pkg::CSP_RUN);
      clk_ctl_out.periph_en = sys_tick;
      clk_ctl_out.fast_osc_en = osc_run;
      clk_ctl_out.slow_osc_en = 1'b1;
      clk_ctl_out.main_reg_en = (state_r != csp_pkg::CSP_SLEEP);
   end

   assign core_periph_blocked_out = (state_r == csp_pkg::CSP_IDLE);
   assign mode_out = state_r;

   // ----------------------------------------
   // wake detection
   // ----------------------------------------
   // edge capture runs on the always-on clock, so level interrupts still wake once
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_prev_r <= '0;
      end else begin
         irq_prev_r <= wake_irq_in;
      end
   end

   assign irq_edge = wake_irq_in & ~irq_prev_r;
   // only the dedicated clockless wake lines reach here
   assign wake_hit = |(irq_edge & wakeup_source_mask_r);
   assign wake_vec = |(irq_edge & wakeup_source_mask_r & irq_enabled_in);
   assign idle_exit = (|(wake_irq_in & irq_enabled_in)) || periph_irq_in;

   // ----------------------------------------
   // power mode sequencer
   // ----------------------------------------
   always_comb begin
      case (rdy_sel_r)
         2'h0: rdy_limit = csp_pkg::RDY_DELAY_0;
         2'h1: rdy_limit = csp_pkg::RDY_DELAY_1;
         2'h2: rdy_limit = csp_pkg::RDY_DELAY_2;
         default: rdy_limit = csp_pkg::RDY_DELAY_3;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         csp_pkg::CSP_RUN: begin
            if (wr_pwr && wdata_in[csp_pkg::PWR_SLEEP_BIT] && wdata_in[csp_pkg::PWR_STOP_BIT]) begin
               state_nxt = csp_pkg::CSP_SLEEP;
            end else if (wr_pwr && wdata_in[csp_pkg::PWR_STOP_BIT]) begin
               state_nxt = csp_pkg::CSP_STOP;
            end else if (wr_pwr && wdata_in[csp_pkg::PWR_IDLE_BIT]) begin
               state_nxt = csp_pkg::CSP_IDLE;
            end
         end
         csp_pkg::CSP_IDLE: begin
            if (idle_exit) begin
               state_nxt = csp_pkg::CSP_RUN;
            end
         end
         csp_pkg::CSP_STOP: begin
            if (wake_hit) begin
               state_nxt = csp_pkg::CSP_RUN;
            end
         end
         csp_pkg::CSP_SLEEP: begin
            if (wake_hit) begin
               state_nxt = csp_pkg::CSP_REGWAIT;
            end
         end
         csp_pkg::CSP_REGWAIT: begin
            if (slow_tick_in && (rdy_cnt_r + 9'h001 >= rdy_limit)) begin
               state_nxt = csp_pkg::CSP_RUN;
            end
         end
         default: state_nxt = csp_pkg::CSP_RUN;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r <= csp_pkg::CSP_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // delay counts slow oscillator ticks only, regardless of the chosen source
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdy_cnt_r <= 9'h000;
      end else if (state_r != csp_pkg::CSP_REGWAIT) begin
         rdy_cnt_r <= 9'h000;
      end else if (slow_tick_in) begin
         rdy_cnt_r <= rdy_cnt_r + 9'h001;
      end
   end

   // vector on stop or sleep wake only when the waking interrupt is enabled; an idle exit always vectors
   always_comb begin
      vector_req_out = 1'b0;
      resume_next_out = 1'b0;
      if (state_r == csp_pkg::CSP_IDLE && idle_exit) begin
         vector_req_out = 1'b1;
      end else if ((state_r == csp_pkg::CSP_STOP || state_r == csp_pkg::CSP_SLEEP) && wake_hit) begin
         vector_req_out = wake_vec;
         resume_next_out = !wake_vec;
      end
   end

   // ----------------------------------------
   // timed access window
   // ----------------------------------------
   // the window counts system clock periods, so it freezes while the clock is gated
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tab_cnt_r <= 9'h000;
         tab_key_r <= 1'b0;
      end else if (wr_in && addr_in == csp_pkg::TAB_ADDR) begin
         tab_key_r <= (wdata_in == csp_pkg::TAB_KEY_FIRST);
         if (wdata_in == csp_pkg::TAB_KEY_CLOSE) begin
            tab_cnt_r <= 9'h000;
         end else if (tab_key_r && wdata_in == csp_pkg::TAB_KEY_SECOND) begin
            tab_cnt_r <= csp_pkg::TAB_WINDOW_CYCLES;
         end else if (sys_tick && tab_open) begin
            tab_cnt_r <= tab_cnt_r - 9'h001;
         end
      end else if (sys_tick && tab_open) begin
         tab_cnt_r <= tab_cnt_r - 9'h001;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         smod_r <= csp_pkg::PWR_RESET[csp_pkg::PWR_SMOD_BIT];
      end else if (wr_pwr) begin
         smod_r <= wdata_in[csp_pkg::PWR_SMOD_BIT];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lower_bit_r <= csp_pkg::PDIV_RESET[csp_pkg::PDIV_LOWER_BIT];
         autosw_r <= csp_pkg::PDIV_RESET[csp_pkg::PDIV_AUTOSW_BIT];
      end else if (wr_in && addr_in == csp_pkg::PDIV_ADDR) begin
         lower_bit_r <= wdata_in[csp_pkg::PDIV_LOWER_BIT];
         autosw_r <= wdata_in[csp_pkg::PDIV_AUTOSW_BIT];
      end
   end

   // settings survive stop and sleep untouched, so the previous clock resumes
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prediv_r <= csp_pkg::CSEL_RESET[csp_pkg::CSEL_DIV_LSB +: 4];
         rdy_sel_r <= csp_pkg::CSEL_RESET[csp_pkg::CSEL_RDY_LSB +: 2];
         src_r <= csp_pkg::CSEL_RESET[csp_pkg::CSEL_SRC_LSB +: 2];
      end else if (wr_prot && addr_in == csp_pkg::CSEL_ADDR) begin
         prediv_r <= wdata_in[csp_pkg::CSEL_DIV_LSB +: 4];
         rdy_sel_r <= wdata_in[csp_pkg::CSEL_RDY_LSB +: 2];
         src_r <= wdata_in[csp_pkg::CSEL_SRC_LSB +: 2];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wakeup_source_mask_r <= csp_pkg::WMASK_RESET;
      end else if (wr_prot && addr_in == csp_pkg::WMASK_ADDR) begin
         wakeup_source_mask_r <= wdata_in;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (addr_in == csp_pkg::PWR_ADDR) begin
         rdata_nxt[csp_pkg::PWR_SMOD_BIT] = smod_r;
      end else if (addr_in == csp_pkg::PDIV_ADDR) begin
         rdata_nxt[csp_pkg::PDIV_UPPER_BIT] = 1'b0;
         rdata_nxt[csp_pkg::PDIV_LOWER_BIT] = lower_bit_r;
         rdata_nxt[csp_pkg::PDIV_AUTOSW_BIT] = autosw_r;
      end else if (addr_in == csp_pkg::CSEL_ADDR) begin
         rdata_nxt[csp_pkg::CSEL_DIV_LSB +: 4] = prediv_r;
         rdata_nxt[csp_pkg::CSEL_SRC_LSB +: 2] = src_r;
      end else if (addr_in == csp_pkg::WMASK_ADDR) begin
         rdata_nxt = wakeup_source_mask_r;
      end else if (addr_in == csp_pkg::TAB_ADDR) begin
         rdata_nxt[csp_pkg::TAB_STAT_BIT] = tab_open;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_r <= 8'h00;
      end else if (rd_in) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata_out = rdata_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_upper_zero;
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == csp_pkg::PDIV_ADDR) |=> (rdata_out[7] == 1'b0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper divider bit read as one");

   property p_rdy_hidden;
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == csp_pkg::CSEL_ADDR) |=> (rdata_out[3:2] == 2'h0);
   endproperty
   a_rdy_hidden: assert property (p_rdy_hidden) else $error("delay field visible");

   property p_locked;
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr_in && !tab_open && (addr_in == csp_pkg::WMASK_ADDR)) |=> $stable(wakeup_source_mask_r);
   endproperty
   a_locked: assert property (p_locked) else $error("mask written while locked");

   property p_sleep_entry;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_r == csp_pkg::CSP_RUN && wr_pwr && wdata_in[2:1] == 2'h3)
         |=> (state_r == csp_pkg::CSP_SLEEP) && !clk_ctl_out.main_reg_en;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_stop_wake;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_r == csp_pkg::CSP_STOP && wake_hit) |=> clk_ctl_out.fast_osc_en;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("oscillator not restarted");

   property p_stop_quiet;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_r == csp_pkg::CSP_STOP) |-> !clk_ctl_out.sys_en && !clk_ctl_out.fast_osc_en;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("clock alive in stop");

   property p_idle_gate;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_r == csp_pkg::CSP_IDLE) |-> !clk_ctl_out.core_en && core_periph_blocked_out;
   endproperty
   a_idle_gate: assert property (p_idle_gate) else $error("core clocked in idle");

   property p_tab_close;
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr_in && addr_in == csp_pkg::TAB_ADDR && wdata_in == 8'h00) |=> !tab_open;
   endproperty
   a_tab_close: assert property (p_tab_close) else $error("window not closed");

   property p_rdy_wait;
      @(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_r == csp_pkg::CSP_REGWAIT) |-> (state_r == csp_pkg::CSP_REGWAIT) [*8];
   endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("regulator delay too short");

   property p_mask_wake;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state_r == csp_pkg::CSP_STOP && (irq_edge & wakeup_source_mask_r) == 8'h00) |=> (state_r != csp_pkg::CSP_RUN);
   endproperty
   a_mask_wake: assert property (p_mask_wake) else $error("masked wake left stop");
endmodule : csp_clock_power
`default_nettype wire

// [rtl/csp_pkg.sv]
package csp_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [7:0] PWR_ADDR = 8'h87;
   localparam logic [7:0] CSEL_ADDR = 8'h8f;
   localparam logic [7:0] WMASK_ADDR = 8'h9f;
   localparam logic [7:0] PDIV_ADDR = 8'hc4;
   localparam logic [7:0] TAB_ADDR = 8'hc9;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PWR_IDLE_BIT = 0;
   localparam int PWR_STOP_BIT = 1;
   localparam int PWR_SLEEP_BIT = 2;
   localparam int PWR_SMOD_BIT = 7;
   localparam int PDIV_UPPER_BIT = 7;
   localparam int PDIV_LOWER_BIT = 6;
   localparam int PDIV_AUTOSW_BIT = 5;
   localparam int CSEL_DIV_LSB = 4;
   localparam int CSEL_RDY_LSB = 2;
   localparam int CSEL_SRC_LSB = 0;
   localparam int TAB_STAT_BIT = 0;
   // ----------------------------------------
   // reset values and codes
   // ----------------------------------------
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam logic [7:0] PDIV_RESET = 8'h40;
   localparam logic [7:0] CSEL_RESET = 8'h0c;
   localparam logic [7:0] WMASK_RESET = 8'hff;
   localparam logic [7:0] TAB_KEY_FIRST = 8'haa;
   localparam logic [7:0] TAB_KEY_SECOND = 8'h55;
   localparam logic [7:0] TAB_KEY_CLOSE = 8'h00;
   localparam logic [1:0] SRC_SLOW = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h3;
   // ----------------------------------------
   // timing counts
   // ----------------------------------------
   localparam logic [8:0] TAB_WINDOW_CYCLES = 9'h100;
   localparam logic [8:0] RDY_DELAY_0 = 9'h008;
   localparam logic [8:0] RDY_DELAY_1 = 9'h010;
   localparam logic [8:0] RDY_DELAY_2 = 9'h040;
   localparam logic [8:0] RDY_DELAY_3 = 9'h100;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {CSP_RUN, CSP_IDLE, CSP_STOP, CSP_SLEEP, CSP_REGWAIT} csp_state_t;
   typedef struct packed {
      logic sys_en;
      logic core_en;
      logic periph_en;
      logic fast_osc_en;
      logic slow_osc_en;
      logic main_reg_en;
   } csp_clk_ctl_t;
endpackage : csp_pkg

// [rtl/csp_prediv.sv]
`timescale 1ns/10ps
`default_nettype none
module csp_prediv (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   input wire logic [3:0] code_in,
   output logic tick_out
);
   logic [7:0] cnt_r;
   logic [7:0] last;

   // ----------------------------------------
   // ratio minus one per code
   // ----------------------------------------
   always_comb begin
      case (code_in)
         4'h0: last = 8'h00;
         4'h1: last = 8'h01;
         4'h2: last = 8'h03;
         4'h3: last = 8'h05;
         4'h4: last = 8'h07;
         4'h5: last = 8'h09;
         4'h6: last = 8'h0b;
         4'h7: last = 8'h0d;
         4'h8: last = 8'h0f;
         4'h9: last = 8'h1f;
         4'ha: last = 8'h3f;
         4'hb: last = 8'h7f;
         default: last = 8'hff;
      endcase
   end

   // counter restarts on oscillator start so the first tick has a full period
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 8'h00;
      end else if (!run_in || cnt_r >= last) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   assign tick_out = run_in && (cnt_r >= last);
endmodule : csp_prediv
`default_nettype wire

// [tb/csp_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// core and wake source model
// ----------------------------------------
module csp_core_model #(
   parameter int SLOW_DIV = 4,
   parameter int EXT_DIV = 3
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] raise_in,
   input wire logic [7:0] drop_in,
   input wire logic [7:0] en_in,
   input wire logic periph_in,
   input wire logic ack_in,
   output logic slow_tick_out,
   output logic ext_tick_out,
   output logic [7:0] wake_irq_out,
   output logic [7:0] irq_en_out,
   output logic periph_irq_out
);
   int slow_cnt;
   int ext_cnt;
   // slow oscillator never stops, not even in sleep
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slow_cnt <= 0;
         ext_cnt <= 0;
      end else begin
         slow_cnt <= (slow_cnt == SLOW_DIV - 1) ? 0 : slow_cnt + 1;
         ext_cnt <= (ext_cnt == EXT_DIV - 1) ? 0 : ext_cnt + 1;
      end
   end
   assign slow_tick_out = (slow_cnt == SLOW_DIV - 1);
   assign ext_tick_out = (ext_cnt == EXT_DIV - 1);
   // lines stay pending until the core takes the wake or drop_in clears them, so a masked line never self-clears
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_irq_out <= 8'h00;
         irq_en_out <= 8'h00;
         periph_irq_out <= 1'h0;
      end else begin
         irq_en_out <= en_in;
         wake_irq_out <= ack_in ? 8'h00 : (wake_irq_out | raise_in) & ~drop_in;
         periph_irq_out <= !ack_in && (periph_irq_out || periph_in);
      end
   end
endmodule : csp_core_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam logic [7:0] A_PWR = 8'h87;
   localparam logic [7:0] A_SEL = 8'h8f;
   localparam logic [7:0] A_MSK = 8'h9f;
   localparam logic [7:0] A_DIV = 8'hc4;
   localparam logic [7:0] A_KEY = 8'hc9;
   localparam int SLOW_DIV = 4;
   localparam int EXT_DIV = 3;
   logic clk_in, rst_n_in, wr_in, rd_in, periph_req, slow_tick, ext_tick, periph_irq;
   logic [7:0] addr_in, wdata_in, rdata_out, raise, drop, en_req, wake_irq, irq_en;
   logic blocked, vec, res, v, r;
   logic [2:0] mode;
   csp_pkg::csp_clk_ctl_t ctl;
   int fails, total_checks, mdl_sel, mdl_msk, mdl_div, mdl_pwr, key, win, p, t, i, j;
   int divs [16] = '{1, 2, 4, 6, 8, 10, 12, 14, 16, 32, 64, 128, 256, 256, 256, 256};
   int srcp [4] = '{1, SLOW_DIV, 1, EXT_DIV};
   int rdy [4] = '{8, 16, 64, 256};
   logic [7:0] regs [6] = '{A_PWR, A_SEL, A_MSK, A_DIV, A_KEY, 8'h40};
   csp_clock_power #(.WAKE_W(8)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .slow_tick_in(slow_tick), .ext_tick_in(ext_tick), .wake_irq_in(wake_irq),
      .irq_enabled_in(irq_en), .periph_irq_in(periph_irq), .clk_ctl_out(ctl),
      .core_periph_blocked_out(blocked), .vector_req_out(vec), .resume_next_out(res),
      .mode_out(mode));
   csp_core_model #(.SLOW_DIV(SLOW_DIV), .EXT_DIV(EXT_DIV)) partner (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .raise_in(raise), .drop_in(drop), .en_in(en_req),
      .periph_in(periph_req), .ack_in(vec | res), .slow_tick_out(slow_tick),
      .ext_tick_out(ext_tick), .wake_irq_out(wake_irq), .irq_en_out(irq_en),
      .periph_irq_out(periph_irq));
   initial begin
      clk_in = 1'h0;
      forever #5 clk_in = ~clk_in;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= w;
      rd_in <= !w;
      @(posedge clk_in);
      wr_in <= 1'h0;
      rd_in <= 1'h0;
      @(negedge clk_in);
      q = rdata_out;
      @(posedge clk_in);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'h1, a, d, q);
      if (a == A_KEY) begin
         win = (d == 8'h00) ? 0 : (key != 0 && d == 8'h55) ? 1 : win;
         key = (d == 8'haa);
      end
      if (a == A_SEL && win != 0) mdl_sel = d;
      if (a == A_MSK && win != 0) mdl_msk = d;
      if (a == A_DIV) mdl_div = d & 8'h60;
      if (a == A_PWR) mdl_pwr = d & 8'h80;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] q;
      logic [7:0] e;
      bus(1'h0, a, 8'h00, q);
      case (a)
         A_PWR: e = 8'(mdl_pwr);
         A_SEL: e = 8'(mdl_sel) & 8'hf3;
         A_MSK: e = 8'(mdl_msk);
         A_DIV: e = 8'(mdl_div);
         A_KEY: e = 8'(win);
         default: e = 8'h00;
      endcase
      check(q, e);
   endtask : rd_chk
   task automatic open_win();
      wr(A_KEY, 8'haa);
      wr(A_KEY, 8'h55);
   endtask : open_win
   task automatic period(output int n);
      int seen;
      seen = 0;
      n = 0;
      while (seen < 3 && n < 3000) begin
         @(negedge clk_in);
         if (ctl.sys_en === 1'h1) seen++;
         if (seen == 2) n++;
      end
      @(posedge clk_in);
   endtask : period
   task automatic pulse(input int k);
      raise <= 8'h01 << k;
      @(posedge clk_in);
      raise <= 8'h00;
   endtask : pulse
   task automatic wake(input logic [2:0] stay, output logic vo, output logic ro);
      vo = 1'h0;
      ro = 1'h0;
      repeat (40) begin
         @(negedge clk_in);
         if (vec === 1'h1) vo = 1'h1;
         if (res === 1'h1) ro = 1'h1;
         if (mode !== stay) break;
      end
      @(posedge clk_in);
   endtask : wake
   task automatic complete_run();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   // hang guard, about three times the expected run length
   initial begin
      #300000;
      fails++;
      complete_run();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst_n_in, wr_in, rd_in, periph_req, addr_in, wdata_in, raise, drop, en_req} = '0;
      {fails, total_checks, mdl_pwr, key, win} = '0;
      mdl_sel = 'h0c;
      mdl_msk = 'hff;
      mdl_div = 'h40;
      void'($urandom(35921));
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'h1;
      @(posedge clk_in);
      foreach (regs[k]) rd_chk(regs[k]);
      wr(A_SEL, 8'h35);
      wr(A_MSK, 8'h00);
      wr(A_DIV, 8'he0);
      foreach (regs[k]) rd_chk(regs[k]);
      wr(A_DIV, 8'h40);
      $display("test registers done");
      wr(A_KEY, 8'haa);
      wr(A_KEY, 8'h12);
      wr(A_KEY, 8'h55);
      rd_chk(A_KEY);
      open_win();
      wr(A_KEY, 8'h00);
      wr(A_SEL, 8'h35);
      rd_chk(A_SEL);
      open_win();
      repeat (200) @(posedge clk_in);
      rd_chk(A_KEY);
      repeat (60) @(posedge clk_in);
      win = 0;
      rd_chk(A_KEY);
      $display("test access window done");
      for (int c = 0; c < 16; c++) begin
         open_win();
         wr(A_SEL, 8'(c << 4));
         period(p);
         check(p, divs[c]);
      end
      for (int s = 0; s < 4; s++) begin
         open_win();
         wr(A_SEL, 8'(s));
         period(p);
         check(p, srcp[s]);
      end
      $display("test clock dividers done");
      open_win();
      wr(A_SEL, 8'h00); // fast oscillator before any low-power mode
      wr(A_PWR, 8'h01);
      @(negedge clk_in);
      check({blocked, ctl.core_en, ctl.periph_en, mode}, {3'h5, 3'h1});
      @(posedge clk_in);
      periph_req <= 1'h1;
      @(posedge clk_in);
      periph_req <= 1'h0;
      wake(3'h1, v, r);
      check({v, blocked, mode}, {2'h2, 3'h0});
      $display("test idle done");
      i = $urandom % 8;
      j = (i + 1 + $urandom % 7) % 8;
      open_win();
      wr(A_SEL, 8'(($urandom % 16) << 4));
      wr(A_MSK, ~(8'h01 << i));
      wr(A_PWR, 8'h02);
      @(negedge clk_in);
      check({mode, ctl.fast_osc_en, ctl.sys_en}, {3'h2, 2'h0});
      @(posedge clk_in);
      pulse(i);
      wake(3'h2, v, r);
      check(mode, 3'h2);
      pulse(j);
      wake(3'h2, v, r);
      check({v, r, mode, ctl.fast_osc_en}, {2'h1, 3'h0, 1'h1});
      rd_chk(A_SEL);
      en_req <= 8'hff;
      pulse(j);
      wr(A_PWR, 8'h02);
      wake(3'h2, v, r);
      check(mode, 3'h2);
      drop <= 8'h01 << j;
      @(posedge clk_in);
      drop <= 8'h00;
      pulse(j);
      wake(3'h2, v, r);
      check({v, r, mode}, {2'h2, 3'h0});
      $display("test stop done");
      for (int c = 0; c < 4; c++) begin
         open_win();
         wr(A_SEL, 8'(c << 2));
         wr(A_PWR, 8'h06);
         @(negedge clk_in);
         check({mode, ctl.main_reg_en, ctl.slow_osc_en, ctl.fast_osc_en}, {3'h3, 3'h2});
         @(posedge clk_in);
         pulse(j);
         t = 0;
         repeat (1500) begin
            @(negedge clk_in);
            if (mode === 3'h4 && slow_tick === 1'h1) t++;
         end
         check({t[12:0], mode}, {rdy[c][12:0], 3'h0});
         @(posedge clk_in);
      end
      $display("test sleep done");
      complete_run();
   end
endmodule : tb
`default_nettype wire
